// File: logic/etd_defs.vh
// Constants for the edge-to-edge delay timer: event codes, command codes, widths.
// Assumes inclusion by bare name from the design file.
`ifndef ETD_DEFS_VH
`define ETD_DEFS_VH

// Event selector layout: bits [3:1] pick the source, bit 0 picks falling (1) or rising (0) for every source but pattern, which is always rising.
`define ETD_SEL_W        4
`define ETD_SEL_SRC_HI   3
`define ETD_SEL_SRC_LO   1
`define ETD_SEL_EDGE     0
`define ETD_SRC_DTR      3'h0
`define ETD_SRC_DSR      3'h1
`define ETD_SRC_RTS      3'h2
`define ETD_SRC_CTS      3'h3
`define ETD_SRC_RLSD     3'h4
`define ETD_SRC_TEST_PT  3'h5
`define ETD_SRC_PATT     3'h6
`define ETD_SRC_DATA     3'h7
`define ETD_START_RST    4'h4
`define ETD_STOP_RST     4'h6

// Remote command codes.
`define ETD_CMD_W        3
`define ETD_CMD_NOP      3'h0
`define ETD_CMD_SET_START 3'h1
`define ETD_CMD_SET_STOP 3'h2
`define ETD_CMD_Q_START  3'h3
`define ETD_CMD_Q_STOP   3'h4
`define ETD_CMD_Q_BOTH   3'h5

`define ETD_CNT_W        32

// Position of each synchronised input in the edge vectors.
`define ETD_PIN_N        10
`define ETD_PIN_DTR      4'h0
`define ETD_PIN_DSR      4'h1
`define ETD_PIN_RTS      4'h2
`define ETD_PIN_CTS      4'h3
`define ETD_PIN_RLSD     4'h4
`define ETD_PIN_TEST_PT  4'h5
`define ETD_PIN_GEN_PAT  4'h6
`define ETD_PIN_RCV_PAT  4'h7
`define ETD_PIN_GEN_DAT  4'h8
`define ETD_PIN_RCV_DAT  4'h9

// Clock edges after reset before edge history is trusted.
`define ETD_PRIME_CYC    2'h3

`endif

// File: logic/etd_delay_timer.v
// Edge-to-edge delay timer: selectable start and stop events, cycle counter,
// and a small remote command port for setting and reading the selectors.
// Assumes line inputs are asynchronous pins; command port is on clk.
//
// Notes on behaviour
// - Start event opens count, stop event closes it.
// - Start selector is written by remote command.
// - Stop selector written independently of start.
// - Control line rising or falling edges selectable.
// - Rear test point edges selectable too.
// - Pattern means generator on start, receiver on stop.
// - Data edge: generator on start, receiver on stop.
// - Start query returns selector without changing it.
// - Stop query returns selector without changing it.
// - Combined query reports both selectors together.
`timescale 1ns/100ps
`include "etd_defs.vh"

module etd_delay_timer #(
    parameter CNT_W = `ETD_CNT_W
) (
    clk,
    srst,
    dtr,
    dsr,
    rts,
    cts,
    rlsd,
    rear_test_point,
    generator_pattern_event,
    receiver_pattern_event,
    generator_data_edge,
    receiver_data_edge,
    cmd_valid,
    cmd_code,
    cmd_sel,
    rsp_valid,
    rsp_start_sel,
    rsp_stop_sel,
    running,
    done,
    delay_count
);
    input  wire                    clk;
    input  wire                    srst;
    input  wire                    dtr;
    input  wire                    dsr;
    input  wire                    rts;
    input  wire                    cts;
    input  wire                    rlsd;
    input  wire                    rear_test_point;
    input  wire                    generator_pattern_event;
    input  wire                    receiver_pattern_event;
    input  wire                    generator_data_edge;
    input  wire                    receiver_data_edge;
    input  wire                    cmd_valid;
    input  wire [`ETD_CMD_W-1:0]   cmd_code;
    input  wire [`ETD_SEL_W-1:0]   cmd_sel;
    output reg                     rsp_valid;
    output reg  [`ETD_SEL_W-1:0]   rsp_start_sel;
    output reg  [`ETD_SEL_W-1:0]   rsp_stop_sel;
    output reg                     running;
    output reg                     done;
    output reg  [CNT_W-1:0]        delay_count;

    localparam NIN = `ETD_PIN_N;

    reg  [`ETD_SEL_W-1:0] start_sel_reg;
    reg  [`ETD_SEL_W-1:0] stop_sel_reg;
    reg  [1:0]            prime_cnt_reg;
    reg  [1:0]            prime_cnt_next;
    reg  [CNT_W-1:0]      count_next;
    wire [NIN-1:0]        rise;
    wire [NIN-1:0]        fall;
    wire                  primed;
    wire [NIN-1:0]        rise_ok;
    wire [NIN-1:0]        fall_ok;
    wire                  start_hit;
    wire                  stop_hit;

    // Each pin gets its own two-stage synchroniser and edge detector.
    etd_edge_sync dtr_edge_u (
        .clk      (clk),
        .srst     (srst),
        .pin_async(dtr),
        .rise     (rise[`ETD_PIN_DTR]),
        .fall     (fall[`ETD_PIN_DTR])
    );
    etd_edge_sync dsr_edge_u (
        .clk      (clk),
        .srst     (srst),
        .pin_async(dsr),
        .rise     (rise[`ETD_PIN_DSR]),
        .fall     (fall[`ETD_PIN_DSR])
    );
    etd_edge_sync rts_edge_u (
        .clk      (clk),
        .srst     (srst),
        .pin_async(rts),
        .rise     (rise[`ETD_PIN_RTS]),
        .fall     (fall[`ETD_PIN_RTS])
    );
    etd_edge_sync cts_edge_u (
        .clk      (clk),
        .srst     (srst),
        .pin_async(cts),
        .rise     (rise[`ETD_PIN_CTS]),
        .fall     (fall[`ETD_PIN_CTS])
    );
    etd_edge_sync rlsd_edge_u (
        .clk      (clk),
        .srst     (srst),
        .pin_async(rlsd),
        .rise     (rise[`ETD_PIN_RLSD]),
        .fall     (fall[`ETD_PIN_RLSD])
    );
    etd_edge_sync test_pt_edge_u (
        .clk      (clk),
        .srst     (srst),
        .pin_async(rear_test_point),
        .rise     (rise[`ETD_PIN_TEST_PT]),
        .fall     (fall[`ETD_PIN_TEST_PT])
    );
    etd_edge_sync gen_pat_edge_u (
        .clk      (clk),
        .srst     (srst),
        .pin_async(generator_pattern_event),
        .rise     (rise[`ETD_PIN_GEN_PAT]),
        .fall     (fall[`ETD_PIN_GEN_PAT])
    );
    etd_edge_sync rcv_pat_edge_u (
        .clk      (clk),
        .srst     (srst),
        .pin_async(receiver_pattern_event),
        .rise     (rise[`ETD_PIN_RCV_PAT]),
        .fall     (fall[`ETD_PIN_RCV_PAT])
    );
    etd_edge_sync gen_dat_edge_u (
        .clk      (clk),
        .srst     (srst),
        .pin_async(generator_data_edge),
        .rise     (rise[`ETD_PIN_GEN_DAT]),
        .fall     (fall[`ETD_PIN_GEN_DAT])
    );
    etd_edge_sync rcv_dat_edge_u (
        .clk      (clk),
        .srst     (srst),
        .pin_async(receiver_data_edge),
        .rise     (rise[`ETD_PIN_RCV_DAT]),
        .fall     (fall[`ETD_PIN_RCV_DAT])
    );

    // History is trusted only once a pin level has passed both stages and the
    // history flop; until then every edge is masked, so a pin idling high
    // cannot fake a rising edge just after reset.
    assign primed  = (prime_cnt_reg == `ETD_PRIME_CYC);
    assign rise_ok = primed ? rise : {NIN{1'h0}};
    assign fall_ok = primed ? fall : {NIN{1'h0}};

    always @* begin
        prime_cnt_next = prime_cnt_reg;
        if (!primed)
            prime_cnt_next = prime_cnt_reg + 2'h1;
    end

    always @(posedge clk) begin
        if (srst)
            prime_cnt_reg <= 2'h0;
        else
            prime_cnt_reg <= prime_cnt_next;
    end

    etd_event_pick #(
        .IS_STOP(0),
        .NIN    (NIN)
    ) start_pick_u (
        .sel (start_sel_reg),
        .rise(rise_ok),
        .fall(fall_ok),
        .hit (start_hit)
    );

    etd_event_pick #(
        .IS_STOP(1),
        .NIN    (NIN)
    ) stop_pick_u (
        .sel (stop_sel_reg),
        .rise(rise_ok),
        .fall(fall_ok),
        .hit (stop_hit)
    );

    // Selectors and query responses.
    always @(posedge clk) begin
        if (srst) begin
            start_sel_reg <= `ETD_START_RST;
            stop_sel_reg  <= `ETD_STOP_RST;
            rsp_valid     <= 1'h0;
            rsp_start_sel <= {`ETD_SEL_W{1'h0}};
            rsp_stop_sel  <= {`ETD_SEL_W{1'h0}};
        end else begin
            rsp_valid <= 1'h0;
            if (cmd_valid) begin
                case (cmd_code)
                    `ETD_CMD_SET_START: start_sel_reg <= cmd_sel;
                    `ETD_CMD_SET_STOP:  stop_sel_reg  <= cmd_sel;
                    `ETD_CMD_Q_START: begin
                        rsp_valid     <= 1'h1;
                        rsp_start_sel <= start_sel_reg;
                        rsp_stop_sel  <= {`ETD_SEL_W{1'h0}};
                    end
                    `ETD_CMD_Q_STOP: begin
                        rsp_valid     <= 1'h1;
                        rsp_start_sel <= {`ETD_SEL_W{1'h0}};
                        rsp_stop_sel  <= stop_sel_reg;
                    end
                    `ETD_CMD_Q_BOTH: begin
                        rsp_valid     <= 1'h1;
                        rsp_start_sel <= start_sel_reg;
                        rsp_stop_sel  <= stop_sel_reg;
                    end
                    default: rsp_valid <= 1'h0;
                endcase
            end
        end
    end

    always @* begin
        count_next = delay_count + {{(CNT_W-1){1'h0}}, 1'h1};
        if (&delay_count)
            count_next = delay_count; // Saturate rather than wrap on a lost stop.
    end

    // Measurement: a start while idle clears and runs; a stop while running freezes.
    // Start and stop in the same cycle while idle opens the interval only;
    // the stop must come from a later cycle.
    always @(posedge clk) begin
        if (srst) begin
            running     <= 1'h0;
            done        <= 1'h0;
            delay_count <= {CNT_W{1'h0}};
        end else begin
            done <= 1'h0;
            if (!running) begin
                if (start_hit) begin
                    running     <= 1'h1;
                    delay_count <= {CNT_W{1'h0}};
                end
            end else if (stop_hit) begin
                running     <= 1'h0;
                done        <= 1'h1;
                delay_count <= count_next;
            end else begin
                delay_count <= count_next;
            end
        end
    end

endmodule // etd_delay_timer

// One pin: two flops ahead of any logic, then one flop of history for the edge compare.
module etd_edge_sync (
    clk,
    srst,
    pin_async,
    rise,
    fall
);
    input  wire clk;
    input  wire srst;
    input  wire pin_async;
    output wire rise;
    output wire fall;

    reg         sync1_reg;
    reg         sync2_reg;
    reg         prev_reg;

    always @(posedge clk) begin
        if (srst) begin
            sync1_reg <= 1'h0;
            sync2_reg <= 1'h0;
            prev_reg  <= 1'h0;
        end else begin
            sync1_reg <= pin_async;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // Only the second stage is compared; the first may still be settling.
    assign rise = sync2_reg & ~prev_reg;
    assign fall = ~sync2_reg & prev_reg;

endmodule // etd_edge_sync

// Picks one edge out of the synchronised vectors for a selector code.
module etd_event_pick #(
    parameter IS_STOP = 0,
    parameter NIN     = `ETD_PIN_N
) (
    sel,
    rise,
    fall,
    hit
);
    input  wire [`ETD_SEL_W-1:0] sel;
    input  wire [NIN-1:0]        rise;
    input  wire [NIN-1:0]        fall;
    output reg                   hit;

    wire [2:0]                   src;
    reg  [3:0]                   idx;

    assign src = sel[`ETD_SEL_SRC_HI:`ETD_SEL_SRC_LO];

    // Pattern flags are levels, so a match counts on its rising edge only.
    always @* begin
        idx = {1'h0, src};
        case (src)
            `ETD_SRC_PATT: idx = (IS_STOP != 0) ? `ETD_PIN_RCV_PAT : `ETD_PIN_GEN_PAT;
            `ETD_SRC_DATA: idx = (IS_STOP != 0) ? `ETD_PIN_RCV_DAT : `ETD_PIN_GEN_DAT;
            default:       idx = {1'h0, src};
        endcase
        if (src == `ETD_SRC_PATT)
            hit = rise[idx];
        else if (sel[`ETD_SEL_EDGE])
            hit = fall[idx];
        else
            hit = rise[idx];
    end

endmodule // etd_event_pick

// File: sim/etd_chk.sv
// Port checker for the delay timer.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module etd_chk #(parameter CNT_W = 32) (
    input wire logic             clk,
    input wire logic             srst,
    input wire logic             cmd_valid,
    input wire logic [2:0]       cmd_code,
    input wire logic [3:0]       cmd_sel,
    input wire logic             rsp_valid,
    input wire logic [3:0]       rsp_start_sel,
    input wire logic [3:0]       rsp_stop_sel,
    input wire logic             running,
    input wire logic             done,
    input wire logic [CNT_W-1:0] delay_count
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_query_answered: assert property (cmd_valid && cmd_code inside {3'h3, 3'h4, 3'h5}
        |=> rsp_valid) else $error("query unanswered");
    a_no_stray_rsp: assert property (!(cmd_valid && cmd_code inside {3'h3, 3'h4, 3'h5})
        |=> !rsp_valid) else $error("stray response");
    a_start_only: assert property (cmd_valid && cmd_code == 3'h3
        |=> rsp_stop_sel == 4'h0) else $error("start query shows stop");
    a_query_same: assert property ((cmd_valid && cmd_code == 3'h5)[*2]
        |=> $stable(rsp_start_sel) && $stable(rsp_stop_sel)) else $error("query changed");
    a_start_set: assert property (cmd_valid && cmd_code == 3'h1 ##1 cmd_valid && cmd_code == 3'h5
        |=> rsp_start_sel == $past(cmd_sel, 2)) else $error("start set lost");
    a_stop_set: assert property (cmd_valid && cmd_code == 3'h2 ##1 cmd_valid && cmd_code == 3'h5
        |=> rsp_stop_sel == $past(cmd_sel, 2)) else $error("stop set lost");
    a_done_ends: assert property (done |-> !running && $past(running)) else $error("bad done");
    a_start_zero: assert property ($rose(running) |-> delay_count == '0) else $error("no clear");
    a_count_up: assert property (running && $past(running) && !$past(srst)
        |-> delay_count == $past(delay_count) + 1'b1) else $error("count not counting");
    a_count_held: assert property (!running && !$past(running) && !$past(srst)
        |-> $stable(delay_count)) else $error("count not held");
endmodule // etd_chk

bind etd_delay_timer etd_chk #(.CNT_W(CNT_W)) chk_u (.clk(clk), .srst(srst),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_sel(cmd_sel), .rsp_valid(rsp_valid),
    .rsp_start_sel(rsp_start_sel), .rsp_stop_sel(rsp_stop_sel), .running(running),
    .done(done), .delay_count(delay_count));

// File: sim/etd_delay_timer_test.sv
// Bench for the delay timer: selectors, queries and measured intervals.
// Assumes the far-side model and bound checker are compiled with it.
`timescale 1ns/100ps
module etd_delay_timer_test;
    logic        clk = 1'h0, srst = 1'h1, cmd_valid = 1'h0, rsp_valid, running, done;
    logic [2:0]  cmd_code = 3'h0;
    logic [3:0]  cmd_sel = 4'h0, rsp_start_sel, rsp_stop_sel;
    logic [9:0]  want = 10'h000, ln;
    logic [31:0] delay_count;
    int          miscompares = 0, num_checks = 0, cycles = 0;
    always #10 clk = ~clk;
    etd_far_model far_u (.clk(clk), .want(want), .lines(ln));
    etd_delay_timer dut_u (.clk(clk), .srst(srst), .dtr(ln[0]), .dsr(ln[1]), .rts(ln[2]),
        .cts(ln[3]), .rlsd(ln[4]), .rear_test_point(ln[5]), .generator_pattern_event(ln[6]),
        .receiver_pattern_event(ln[7]), .generator_data_edge(ln[8]), .receiver_data_edge(ln[9]),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_sel(cmd_sel), .rsp_valid(rsp_valid),
        .rsp_start_sel(rsp_start_sel), .rsp_stop_sel(rsp_stop_sel), .running(running),
        .done(done), .delay_count(delay_count));
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Leaves the strobe up so that two calls make back-to-back commands.
    task automatic send(logic [2:0] code, logic [3:0] sel);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_sel = sel;
    endtask
    task automatic query(logic [2:0] code, logic [3:0] st, logic [3:0] sp);
        send(code, 4'h0);
        @(negedge clk);
        cmd_valid = 1'h0;
        check("rsp_valid", rsp_valid, 1);
        check("rsp_start_sel", rsp_start_sel, st);
        check("rsp_stop_sel", rsp_stop_sel, sp);
    endtask
    task automatic measure(logic [2:0] s, logic f, int gap);
        int a, b, n;
        logic [2:0] t;
        logic pa, pb;
        t = (s > 3'h5) ? s : ((s == 3'h5) ? 3'h0 : s + 3'h1);
        a = (s < 3'h6) ? s : ((s == 3'h6) ? 6 : 8);
        b = (t < 3'h6) ? t : ((t == 3'h6) ? 7 : 9);
        pa = f && (s != 3'h6);
        pb = f && (t != 3'h6);
        @(negedge clk);
        want[a] <= pa;
        want[b] <= pb;
        srst <= 1'b1;
        repeat (3) @(negedge clk);
        srst <= 1'b0;
        send(3'h1, {s, f});
        send(3'h2, {t, f});
        query(3'h5, {s, f}, {t, f});
        repeat (3) @(negedge clk);
        want[a] <= ~pa;
        repeat (gap) @(negedge clk);
        want[b] <= ~pb;
        repeat (2) @(negedge clk);
        check("running", running, 1);
        n = 0;
        while (done !== 1'h1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("done", done, 1);
        check("stopped", running, 0);
        check("delay_count", delay_count, gap);
        repeat (4) @(negedge clk);
        check("held_count", delay_count, gap);
        $display("test measure %0d %0d ended", s, f);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            report_and_stop;
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        srst <= 1'b0;
        send(3'h5, 4'h0);
        query(3'h5, 4'h4, 4'h6);
        query(3'h3, 4'h4, 4'h0);
        send(3'h6, 4'h3);
        query(3'h4, 4'h0, 4'h6);
        send(3'h1, 4'h7);
        query(3'h5, 4'h7, 4'h6);
        $display("test queries ended");
        for (int s = 0; s < 8; s++) begin
            for (int f = 0; f < 2; f++) begin
                measure(s[2:0], f[0], 2 + s);
            end
        end
        report_and_stop;
    end
endmodule // etd_delay_timer_test

// File: sim/etd_far_model.sv
// Far-side model: drives control lines, test point, pattern and data levels.
// Assumes the bench sets wanted levels; they reach the pins at the falling edge.
`timescale 1ns/100ps
module etd_far_model (
    input  wire logic       clk,
    input  wire logic [9:0] want,
    output logic      [9:0] lines
);
    initial lines = 10'h000;
    always @(negedge clk) begin
        lines <= want;
    end
endmodule // etd_far_model
